/* File: design/gctl_pkg.sv */
package gctl_pkg;
  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] IDX_FAMILY   = 8'h00;  // chip_family_ident
  localparam logic [7:0] IDX_IDRUN    = 8'h01;  // chip_ident_and_run
  localparam logic [7:0] IDX_GCTL0    = 8'h02;  // global_control_zero
  localparam logic [7:0] IDX_GCTL1    = 8'h03;  // global_control_one
  // decoded regions, inclusive bounds
  localparam logic [7:0] GLB_LO       = 8'h00;
  localparam logic [7:0] GLB_HI       = 8'h0F;
  localparam logic [7:0] P1_LO        = 8'h10;
  localparam logic [7:0] P1_HI        = 8'h1D;
  localparam logic [7:0] P2_LO        = 8'h20;
  localparam logic [7:0] P2_HI        = 8'h2D;
  localparam logic [7:0] P3_LO        = 8'h30;
  localparam logic [7:0] P3_HI        = 8'h39;
  localparam logic [7:0] IAC_LO       = 8'h79;
  localparam logic [7:0] IAC_HI       = 8'h7A;
  localparam logic [7:0] IDT_LO       = 8'h7B;
  localparam logic [7:0] IDT_HI       = 8'h83;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int RUN_BIT      = 0;  // in chip_ident_and_run
  localparam int ALT_BO_BIT   = 7;  // global_control_zero
  localparam int PURGE_L_BIT  = 5;
  localparam int PURGE_F_BIT  = 4;
  localparam int PASS_FC_BIT  = 3;
  localparam int PASS_ALL_BIT = 7;  // global_control_one
  localparam int TAIL_BIT     = 6;
  localparam int TX_FC_BIT    = 5;
  localparam int RX_FC_BIT    = 4;
  localparam int LEN_CHK_BIT  = 3;
  localparam int AGE_EN_BIT   = 2;
  localparam int FAST_AGE_BIT = 1;
  localparam int AGGR_BO_BIT  = 0;
  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic       RUN_RST    = 1'b1;
  localparam logic [7:0] GCTL0_RST  = 8'h00;
  localparam logic [7:0] GCTL0_WMSK = 8'hBE;  // bits 6 and 0 read-only zero
  localparam logic [7:0] GCTL1_RST  = 8'h34;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int FAST_AGE_US   = 800;
  localparam int FAST_AGE_CYC  = FAST_AGE_US * CLK_MHZ;
  localparam int LEN_CHK_LIMIT = 1500;  // length/type below this is checked
  // control bits handed to the switch core
  typedef struct packed {
    logic run;
    logic alt_backoff;
    logic purge_learned_entries;
    logic purge_fixed_entries;
    logic pass_fc_frames;
    logic tail_tag_en;
    logic pause_tx_en;
    logic pause_rx_en;
    logic len_check_en;
    logic aging_en;
    logic fast_age;
    logic aggr_backoff;
  } ctrl_t;
endpackage : gctl_pkg

/* File: design/switch_global_control_bank.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - 8-bit registers, ids then global controls 0x00-0x0F
// - port blocks decode 0x10-1D, 0x20-2D, 0x30-39
// - indirect control 0x79-7A, data 0x7B-83 decode
// - run bit starts/stops switching, resets to one
// - bit 7 picks alternative back-off, reset zero
// - bit 5 purges learned address entries
// - bit 4 purges fixed address entries
// - bit 3 forwards flow control frames, reset zero
// - pass bad frames only with sniffer mode
// - bit 6 enables processor-port trailer tagging
// - bit 5 enables pause generation, reset one
// - bit 4 enables pause response, reset one
// - bit 3 enables length field check below 1500
// - bit 2 enables aging, reset one
// - bit 1 selects 800 us fast aging
module switch_global_control_bank #(
  parameter int              AW            = 10,
  parameter logic [7:0]      FAMILY_CODE   = 8'h5A,  // arbitrary value
  parameter logic [3:0]      PART_CODE     = 4'h6,   // arbitrary value
  parameter logic [2:0]      SILICON_REV   = 3'h1,   // arbitrary value
  parameter int unsigned     FAST_AGE_CYCS = gctl_pkg::FAST_AGE_CYC,
  parameter int unsigned     NORM_AGE_CYCS = 30000000
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  // axi4-lite write address
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // axi4-lite read
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // switch core side
  input  wire logic          sniffer_mode,
  output gctl_pkg::ctrl_t    ctrl,
  output logic               pass_bad_frames,
  output logic               age_tick
);
  import gctl_pkg::*;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // a mapped index answers okay; anything else answers slverr
  function automatic logic idx_mapped(input logic [7:0] i);
    logic m;
    m = 1'b0;
    if (i <= GLB_HI) m = 1'b1;
    if (i >= P1_LO && i <= P1_HI) m = 1'b1;
    if (i >= P2_LO && i <= P2_HI) m = 1'b1;
    if (i >= P3_LO && i <= P3_HI) m = 1'b1;
    if (i >= IAC_LO && i <= IAC_HI) m = 1'b1;
    if (i >= IDT_LO && i <= IDT_HI) m = 1'b1;
    return m;
  endfunction : idx_mapped

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic          aw_have_q, aw_have_d;    // address taken, waiting
  logic [7:0]    aw_idx_q,  aw_idx_d;     // held write index
  logic          w_have_q,  w_have_d;     // data taken, waiting
  logic [7:0]    wdat_q,    wdat_d;       // low byte only matters
  logic          wstb_q,    wstb_d;       // lane 0 strobe
  logic          awrdy_q,   awrdy_d;
  logic          wrdy_q,    wrdy_d;
  logic          bvld_q,    bvld_d;
  logic [1:0]    bresp_q,   bresp_d;
  logic          arrdy_q,   arrdy_d;
  logic          rvld_q,    rvld_d;
  logic [1:0]    rresp_q,   rresp_d;
  logic [31:0]   rdat_q,    rdat_d;
  logic          run_q,     run_d;        // start/stop bit
  logic [7:0]    gc0_q,     gc0_d;        // global_control_zero
  logic [7:0]    gc1_q,     gc1_d;        // global_control_one
  logic          pbad_q,    pbad_d;
  logic [31:0]   age_cnt_q, age_cnt_d;
  logic          tick_q,    tick_d;
  logic          do_wr;                   // both halves held
  logic [31:0]   age_lim;                 // current interval minus one

  // ----------------------------------------
  // write channel and registers
  // ----------------------------------------
  // both halves may arrive in either order; a response blocks new ones
  always_comb begin
    aw_have_d = aw_have_q;
    aw_idx_d  = aw_idx_q;
    w_have_d  = w_have_q;
    wdat_d    = wdat_q;
    wstb_d    = wstb_q;
    bvld_d    = bvld_q;
    bresp_d   = bresp_q;
    run_d     = run_q;
    gc0_d     = gc0_q;
    gc1_d     = gc1_q;
    do_wr     = aw_have_q && w_have_q && !bvld_q;
    if (s_axi_awvalid && awrdy_q) begin
      aw_have_d = 1'b1;
      aw_idx_d  = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && wrdy_q) begin
      w_have_d = 1'b1;
      wdat_d   = s_axi_wdata[7:0];
      wstb_d   = s_axi_wstrb[0];
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvld_d    = 1'b1;
      bresp_d   = idx_mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
      if (wstb_q) begin
        // only writable bits are taken; ids never change
        unique case (aw_idx_q)
          IDX_IDRUN: run_d = wdat_q[RUN_BIT];
          IDX_GCTL0: gc0_d = wdat_q & GCTL0_WMSK;
          IDX_GCTL1: gc1_d = wdat_q;
          default: ;                                       // other regions hold no storage
        endcase
      end
    end else if (bvld_q && s_axi_bready) begin
      bvld_d = 1'b0;
    end
    // ready drops while a half is held or a response waits
    awrdy_d = !aw_have_d && !bvld_d;
    wrdy_d  = !w_have_d && !bvld_d;
  end

  // register the write side
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      aw_have_q <= 1'b0;
      aw_idx_q  <= 8'h00;
      w_have_q  <= 1'b0;
      wdat_q    <= 8'h00;
      wstb_q    <= 1'b0;
      awrdy_q   <= 1'b0;
      wrdy_q    <= 1'b0;
      bvld_q    <= 1'b0;
      bresp_q   <= RESP_OKAY;
      run_q     <= RUN_RST;
      gc0_q     <= GCTL0_RST;
      gc1_q     <= GCTL1_RST;
    end else begin
      aw_have_q <= aw_have_d;
      aw_idx_q  <= aw_idx_d;
      w_have_q  <= w_have_d;
      wdat_q    <= wdat_d;
      wstb_q    <= wstb_d;
      awrdy_q   <= awrdy_d;
      wrdy_q    <= wrdy_d;
      bvld_q    <= bvld_d;
      bresp_q   <= bresp_d;
      run_q     <= run_d;
      gc0_q     <= gc0_d;
      gc1_q     <= gc1_d;
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  // one read at a time; data lands one cycle after the address is taken
  always_comb begin
    arrdy_d = arrdy_q;
    rvld_d  = rvld_q;
    rresp_d = rresp_q;
    rdat_d  = rdat_q;
    if (s_axi_arvalid && arrdy_q) begin
      arrdy_d = 1'b0;
      rvld_d  = 1'b1;
      rresp_d = idx_mapped(s_axi_araddr[9:2]) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr[9:2])
        IDX_FAMILY: rdat_d = {24'h000000, FAMILY_CODE};
        IDX_IDRUN:  rdat_d = {24'h000000, PART_CODE, SILICON_REV, run_q};
        IDX_GCTL0:  rdat_d = {24'h000000, gc0_q};
        IDX_GCTL1:  rdat_d = {24'h000000, gc1_q};
        default:    rdat_d = 32'h00000000;  // unbacked and unmapped read zero
      endcase
    end else if (rvld_q && s_axi_rready) begin
      rvld_d  = 1'b0;
      arrdy_d = 1'b1;
    end
  end

  // register the read side
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      arrdy_q <= 1'b1;
      rvld_q  <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdat_q  <= 32'h00000000;
    end else begin
      arrdy_q <= arrdy_d;
      rvld_q  <= rvld_d;
      rresp_q <= rresp_d;
      rdat_q  <= rdat_d;
    end
  end

  // ----------------------------------------
  // core-side qualifiers and aging timer
  // ----------------------------------------
  // bad-frame forwarding is meaningless outside sniffing, so gate it here
  always_comb begin
    pbad_d    = gc1_q[PASS_ALL_BIT] && sniffer_mode;
    age_lim   = (gc1_q[FAST_AGE_BIT] ? FAST_AGE_CYCS : NORM_AGE_CYCS) - 32'h00000001;
    tick_d    = 1'b0;
    age_cnt_d = age_cnt_q;
    if (!gc1_q[AGE_EN_BIT]) begin
      age_cnt_d = 32'h00000000;  // aging off: timer parked
    end else if (age_cnt_q >= age_lim) begin
      // a shortened limit takes effect at once, no long wrap
      age_cnt_d = 32'h00000000;
      tick_d    = 1'b1;
    end else begin
      age_cnt_d = age_cnt_q + 32'h00000001;
    end
  end

  // register core-side state
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pbad_q    <= 1'b0;
      age_cnt_q <= 32'h00000000;
      tick_q    <= 1'b0;
    end else begin
      pbad_q    <= pbad_d;
      age_cnt_q <= age_cnt_d;
      tick_q    <= tick_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = bvld_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid  = rvld_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdat_q;
  assign pass_bad_frames = pbad_q;
  assign age_tick        = tick_q;
  // control bits straight from their register flops
  assign ctrl.run                   = run_q;
  assign ctrl.alt_backoff           = gc0_q[ALT_BO_BIT];
  assign ctrl.purge_learned_entries = gc0_q[PURGE_L_BIT];
  assign ctrl.purge_fixed_entries   = gc0_q[PURGE_F_BIT];
  assign ctrl.pass_fc_frames        = gc0_q[PASS_FC_BIT];
  assign ctrl.tail_tag_en           = gc1_q[TAIL_BIT];
  assign ctrl.pause_tx_en           = gc1_q[TX_FC_BIT];
  assign ctrl.pause_rx_en           = gc1_q[RX_FC_BIT];
  assign ctrl.len_check_en          = gc1_q[LEN_CHK_BIT];
  assign ctrl.aging_en              = gc1_q[AGE_EN_BIT];
  assign ctrl.fast_age              = gc1_q[FAST_AGE_BIT];
  assign ctrl.aggr_backoff          = gc1_q[AGGR_BO_BIT];

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_run_reset: assert property (@(posedge clk_sys)
    $rose(rstn) |-> ctrl.run && ctrl.pause_tx_en && ctrl.pause_rx_en && ctrl.aging_en
      && !ctrl.alt_backoff && !ctrl.pass_fc_frames && !ctrl.tail_tag_en)
    else $error("control bits wrong after reset");
  a_run_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    do_wr && wstb_q && aw_idx_q == IDX_IDRUN |=> ctrl.run == $past(wdat_q[0]))
    else $error("run bit did not take written value");
  a_gc0_ro_bits: assert property (@(posedge clk_sys) disable iff (!rstn)
    gc0_q[6] == 1'b0 && gc0_q[0] == 1'b0)
    else $error("read-only bits of control zero changed");
  a_id_read: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == IDX_IDRUN
      |=> s_axi_rvalid && s_axi_rdata[7:1] == {PART_CODE, SILICON_REV})
    else $error("id read returned wrong value");
  a_map_resp: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] inside {[P2_LO:P2_HI]}
      |=> s_axi_rresp == RESP_OKAY)
    else $error("port region read refused");
  a_unmapped_err: assert property (@(posedge clk_sys) disable iff (!rstn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == 8'h84
      |=> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  a_sniff_gate: assert property (@(posedge clk_sys) disable iff (!rstn)
    pass_bad_frames |-> $past(sniffer_mode) && $past(gc1_q[PASS_ALL_BIT]))
    else $error("bad frames passed without sniffer mode");
  a_age_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    !gc1_q[AGE_EN_BIT] ##1 !gc1_q[AGE_EN_BIT] |-> !age_tick)
    else $error("aging tick while aging disabled");
  a_fast_gap: assert property (@(posedge clk_sys) disable iff (!rstn)
    age_tick && gc1_q[FAST_AGE_BIT] |-> age_cnt_q < FAST_AGE_CYCS)
    else $error("fast aging counter ran past its interval");
  a_b_resp: assert property (@(posedge clk_sys) disable iff (!rstn)
    do_wr |=> s_axi_bvalid [*1] ##0 !s_axi_awready && !s_axi_wready)
    else $error("write response missing after both halves");
endmodule : switch_global_control_bank
`default_nettype wire

/* File: test/host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// host side of the register bus
// ----------------------------------------
module host_model #(
  parameter int AW = 10
) (
  // clock
  input  wire logic          clk_sys,
  // write channels
  output logic [AW-1:0]      awaddr,
  output logic               awvalid,
  input  wire logic          awready,
  output logic [31:0]        wdata,
  output logic [3:0]         wstrb,
  output logic               wvalid,
  input  wire logic          wready,
  input  wire logic [1:0]    bresp,
  input  wire logic          bvalid,
  output logic               bready,
  // read channels
  output logic [AW-1:0]      araddr,
  output logic               arvalid,
  input  wire logic          arready,
  input  wire logic [31:0]   rdata,
  input  wire logic [1:0]    rresp,
  input  wire logic          rvalid,
  output logic               rready
);
  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat,
                    input logic [3:0] strb, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge clk_sys);
    awaddr  <= AW'({idx, 2'h0});
    wdata   <= {24'h000000, dat};
    wstrb   <= strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      // released lines show the inverse, never a stale value
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
        awaddr  <= ~awaddr;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
        wdata  <= ~wdata;
      end
    end
    // no bound here: the bench watchdog cuts a hang
    while (bvalid !== 1'b1) @(posedge clk_sys);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  // read: address held until taken, rready until data seen
  task automatic rd(input logic [7:0] idx, output logic [31:0] data,
                    output logic [1:0] resp);
    @(posedge clk_sys);
    araddr  <= AW'({idx, 2'h0});
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr  <= ~araddr;
    while (rvalid !== 1'b1) @(posedge clk_sys);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : host_model
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gctl_pkg::*;
  // ----------------------------------------
  // setup
  // ----------------------------------------
  localparam logic [7:0] FAM  = 8'hC4;  // arbitrary value
  localparam logic [3:0] PART = 4'h9;   // arbitrary value
  localparam logic [2:0] REV  = 3'h5;   // arbitrary value
  // short aging counts keep the run brief
  localparam int         FAST = 20;
  localparam int         NORM = 50;
  // decode table: {error expected, index}
  localparam logic [8:0] DEC [15] = '{9'h004, 9'h00F, 9'h010, 9'h01D, 9'h11E,
    9'h020, 9'h02D, 9'h12E, 9'h030, 9'h039, 9'h13A, 9'h178, 9'h079, 9'h083, 9'h184};
  logic        clk_sys, rstn, sniffer_mode;
  logic [9:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  ctrl_t       ctrl;
  logic        pass_bad_frames, age_tick;
  int          bad_count, tests_run, n;
  switch_global_control_bank #(.FAMILY_CODE(FAM), .PART_CODE(PART), .SILICON_REV(REV),
    .FAST_AGE_CYCS(FAST), .NORM_AGE_CYCS(NORM)) switch_global_control_bank_inst (
    .clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sniffer_mode(sniffer_mode), .ctrl(ctrl), .pass_bad_frames(pass_bad_frames),
    .age_tick(age_tick));
  host_model host_model_inst (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wchk(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] er);
    logic [1:0] r;
    host_model_inst.wr(idx, d, s, r);
    check(32'(r), 32'(er));
  endtask : wchk
  task automatic rchk(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    host_model_inst.rd(idx, d, r);
    check(d, ed);
    check(32'(r), 32'(er));
  endtask : rchk
  // cycles from one aging tick to the next, sampled on falling edges
  task automatic gap(output int c);
    c = 0;
    @(negedge clk_sys);
    while (age_tick !== 1'b1 && c < 300) begin
      @(negedge clk_sys);
      c++;
    end
    c = 0;
    do begin
      @(negedge clk_sys);
      c++;
    end while (age_tick !== 1'b1 && c < 300);
  endtask : gap
  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    bad_count = 0;
    tests_run = 0;
    rstn = 1'b0;
    sniffer_mode = 1'b0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check(32'(ctrl), 32'h834);
    rchk(IDX_FAMILY, {24'h0, FAM}, RESP_OKAY);
    rchk(IDX_IDRUN, {24'h0, PART, REV, 1'b1}, RESP_OKAY);
    rchk(IDX_GCTL0, 32'h0, RESP_OKAY);
    rchk(IDX_GCTL1, 32'h34, RESP_OKAY);
    // id fields hold, only the run bit moves
    wchk(IDX_FAMILY, 8'h00, 4'hF, RESP_OKAY);
    rchk(IDX_FAMILY, {24'h0, FAM}, RESP_OKAY);
    wchk(IDX_IDRUN, 8'h00, 4'hF, RESP_OKAY);
    rchk(IDX_IDRUN, {24'h0, PART, REV, 1'b0}, RESP_OKAY);
    check(32'(ctrl.run), 32'h0);
    wchk(IDX_IDRUN, 8'h01, 4'hF, RESP_OKAY);
    check(32'(ctrl.run), 32'h1);
    // read-only bits 6 and 0 stay zero when written with ones
    wchk(IDX_GCTL0, 8'hF9, 4'hF, RESP_OKAY);
    rchk(IDX_GCTL0, 32'hB8, RESP_OKAY);
    check(32'(ctrl[10:7]), 32'hF);
    wchk(IDX_GCTL0, 8'h00, 4'hF, RESP_OKAY);
    check(32'(ctrl[10:7]), 32'h0);
    // a write with the low byte lane off stores nothing
    wchk(IDX_GCTL1, 8'hFF, 4'h0, RESP_OKAY);
    rchk(IDX_GCTL1, 32'h34, RESP_OKAY);
    // walk a single one through the second control register
    for (int b = 7; b >= 0; b--) begin
      wchk(IDX_GCTL1, 8'h01 << b, 4'hF, RESP_OKAY);
      rchk(IDX_GCTL1, 32'h1 << b, RESP_OKAY);
      check(32'(ctrl[6:0]), 32'(7'((8'h01 << b) & 8'h7F)));
    end
    // debug forwarding needs sniffer mode as well
    wchk(IDX_GCTL1, 8'h80, 4'hF, RESP_OKAY);
    repeat (2) @(negedge clk_sys);
    check(32'(pass_bad_frames), 32'h0);
    @(posedge clk_sys) sniffer_mode <= 1'b1;
    repeat (2) @(negedge clk_sys);
    check(32'(pass_bad_frames), 32'h1);
    @(posedge clk_sys) sniffer_mode <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check(32'(pass_bad_frames), 32'h0);
    // aging off: no tick at all
    wchk(IDX_GCTL1, 8'h00, 4'hF, RESP_OKAY);
    n = 0;
    repeat (120) begin
      @(negedge clk_sys);
      n += int'(age_tick === 1'b1);
    end
    check(32'(n), 32'h0);
    wchk(IDX_GCTL1, 8'h06, 4'hF, RESP_OKAY);
    gap(n);
    check(32'(n), 32'(FAST));
    wchk(IDX_GCTL1, 8'h04, 4'hF, RESP_OKAY);
    gap(n);
    check(32'(n), 32'(NORM));
    // address map: mapped places answer okay, holes refuse
    for (int i = 0; i < 15; i++) begin
      rchk(DEC[i][7:0], 32'h0, DEC[i][8] ? RESP_SLVERR : RESP_OKAY);
      wchk(DEC[i][7:0], 8'hFF, 4'hF, DEC[i][8] ? RESP_SLVERR : RESP_OKAY);
    end
    rchk(IDX_GCTL1, 32'h04, RESP_OKAY);
    finish_test();
  end
  // hang guard, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
